// file: design/ifp_irq_ctrl.sv
// Flag, enable and priority registers for two pin and ten peripheral interrupt sources.
// Assumes event inputs are one-cycle pulses synchronous to sys_clk_in.
`timescale 1ns/10ps
`default_nettype none
module ifp_irq_ctrl
  import ifp_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Register port.
  input wire logic [IFP_AW-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Event sources.
  input wire logic pin1_event_in,
  input wire logic pin2_event_in,
  input wire logic conv_done_in,
  input wire logic serial_rx_full_in,
  input wire logic serial_tx_empty_in,
  input wire logic serial_rx_buffer_read_in,
  input wire logic serial_tx_buffer_write_in,
  input wire logic [1:0] ccp_mode_in,
  input wire logic ccp_event_in,
  input wire logic timer_two_match_in,
  input wire logic timer_one_overflow_in,
  input wire logic osc_fail_in,
  input wire logic nv_write_done_in,
  input wire logic low_voltage_in,
  input wire logic timer_three_overflow_in,
  // Requests to the core.
  output logic irq_high_out,
  output logic irq_low_out,
  output logic [23:0] irq_vector_out
);

  typedef struct packed {
    logic [7:0] pinctl3;
    logic [7:0] flags1;
    logic [7:0] flags2;
    logic [7:0] en1;
    logic [7:0] en2;
    logic [7:0] pri1;
    logic [7:0] pri2;
    logic [7:0] core;
    logic [7:0] rdata;
    logic irq_high;
    logic irq_low;
    logic [23:0] vector;
  } ifp_state_type;

  ifp_state_type state_q;
  ifp_state_type state_d;

  logic [7:0] set1;
  logic [7:0] set2;
  logic [7:0] setp;
  logic [7:0] pend1;
  logic [7:0] pend2;
  logic pin1_act;
  logic pin2_act;
  logic hi_req;
  logic lo_req;
  logic priority_scheme_enable;

  // Hardware set terms for each sticky flag.
  always_comb begin
    set1 = 8'h00;
    set2 = 8'h00;
    setp = 8'h00;
    setp[IFP_B_P1FLG] = pin1_event_in;
    setp[IFP_B_P2FLG] = pin2_event_in;
    set1[IFP_B_CONV] = conv_done_in;
    // The flag ignores events while the unit runs PWM.
    set1[IFP_B_CAPC] = ccp_event_in && ((ccp_mode_in == IFP_CCP_CAPTURE) || (ccp_mode_in == IFP_CCP_COMPARE));
    set1[IFP_B_T2M] = timer_two_match_in;
    set1[IFP_B_T1O] = timer_one_overflow_in;
    set2[IFP_B_OSCF] = osc_fail_in;
    set2[IFP_B_NVW] = nv_write_done_in;
    set2[IFP_B_LOWV] = low_voltage_in;
    set2[IFP_B_T3O] = timer_three_overflow_in;
  end

  // Request combination from the current register state.
  always_comb begin
    priority_scheme_enable = state_q.core[IFP_B_PRIORITY_SCHEME_ENABLE];
    pend1 = state_q.flags1 & state_q.en1;
    pend2 = state_q.flags2 & state_q.en2;
    pin1_act = state_q.pinctl3[IFP_B_P1FLG] && state_q.pinctl3[IFP_B_P1EN];
    pin2_act = state_q.pinctl3[IFP_B_P2FLG] && state_q.pinctl3[IFP_B_P2EN];
    hi_req = 1'b0;
    lo_req = 1'b0;
    if (!priority_scheme_enable) begin
      // Compatibility: everything is high and peripherals need their own gate.
      hi_req = state_q.core[IFP_B_GIE] && (pin1_act || pin2_act ||
               (state_q.core[IFP_B_PERIPHERAL_IRQ_GLOBAL_ENABLE] && ((pend1 | pend2) != 8'h00)));
    end else begin
      // The two global bits act as high and low gates.
      hi_req = state_q.core[IFP_B_GIE] && ((pin1_act && state_q.pinctl3[IFP_B_P1PRI]) ||
               (pin2_act && state_q.pinctl3[IFP_B_P2PRI]) ||
               ((pend1 & state_q.pri1) != 8'h00) || ((pend2 & state_q.pri2) != 8'h00));
      lo_req = state_q.core[IFP_B_PERIPHERAL_IRQ_GLOBAL_ENABLE] && ((pin1_act && !state_q.pinctl3[IFP_B_P1PRI]) ||
               (pin2_act && !state_q.pinctl3[IFP_B_P2PRI]) ||
               ((pend1 & ~state_q.pri1) != 8'h00) || ((pend2 & ~state_q.pri2) != 8'h00));
    end
  end

  // Next state: register writes, then hardware sets so that a set wins.
  always_comb begin
    state_d = state_q;
    if (reg_wr_in) begin
      if (reg_addr_in == IFP_OFF_PINCTL3) begin
        state_d.pinctl3 = reg_wdata_in & IFP_PINCTL3_MASK;
      end else if (reg_addr_in == IFP_OFF_PFLAG1) begin
        state_d.flags1 = (state_q.flags1 & ~IFP_P1_SWMASK) | (reg_wdata_in & IFP_P1_SWMASK);
      end else if (reg_addr_in == IFP_OFF_PFLAG2) begin
        state_d.flags2 = reg_wdata_in & IFP_P2_MASK;
      end else if (reg_addr_in == IFP_OFF_PEN1) begin
        state_d.en1 = reg_wdata_in & IFP_P1_MASK;
      end else if (reg_addr_in == IFP_OFF_PEN2) begin
        state_d.en2 = reg_wdata_in & IFP_P2_MASK;
      end else if (reg_addr_in == IFP_OFF_PPRI1) begin
        state_d.pri1 = reg_wdata_in & IFP_P1_MASK;
      end else if (reg_addr_in == IFP_OFF_PPRI2) begin
        state_d.pri2 = reg_wdata_in & IFP_P2_MASK;
      end else if (reg_addr_in == IFP_OFF_CORECTL) begin
        state_d.core = reg_wdata_in & IFP_CORE_MASK;
      end
    end
    state_d.pinctl3 = state_d.pinctl3 | setp;
    state_d.flags1 = state_d.flags1 | set1;
    state_d.flags2 = state_d.flags2 | set2;
    // Buffer status flags are levels owned by the serial unit; a buffer access clears at once.
    state_d.flags1[IFP_B_RXF] = serial_rx_full_in && !serial_rx_buffer_read_in;
    state_d.flags1[IFP_B_TXE] = serial_tx_empty_in && !serial_tx_buffer_write_in;
    // Read data for the cycle after the strobe; unmapped offsets read zero.
    state_d.rdata = 8'h00;
    if (reg_rd_in) begin
      if (reg_addr_in == IFP_OFF_PINCTL3) begin
        state_d.rdata = state_q.pinctl3;
      end else if (reg_addr_in == IFP_OFF_PFLAG1) begin
        state_d.rdata = state_q.flags1;
      end else if (reg_addr_in == IFP_OFF_PFLAG2) begin
        state_d.rdata = state_q.flags2;
      end else if (reg_addr_in == IFP_OFF_PEN1) begin
        state_d.rdata = state_q.en1;
      end else if (reg_addr_in == IFP_OFF_PEN2) begin
        state_d.rdata = state_q.en2;
      end else if (reg_addr_in == IFP_OFF_PPRI1) begin
        state_d.rdata = state_q.pri1;
      end else if (reg_addr_in == IFP_OFF_PPRI2) begin
        state_d.rdata = state_q.pri2;
      end else if (reg_addr_in == IFP_OFF_CORECTL) begin
        state_d.rdata = state_q.core;
      end else if (reg_addr_in == IFP_OFF_VECTOR) begin
        state_d.rdata = state_q.vector[7:0];
      end
    end
    // High wins the vector; compatibility mode always uses the high vector.
    state_d.irq_high = hi_req;
    state_d.irq_low = lo_req && !hi_req;
    state_d.vector = lo_req && !hi_req ? IFP_VEC_LOW : IFP_VEC_HIGH;
  end

  // State register.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= '0;
      state_q.pinctl3 <= IFP_PINCTL3_RST;
      state_q.pri1 <= IFP_P1_MASK;
      state_q.pri2 <= IFP_P2_MASK;
      state_q.vector <= IFP_VEC_HIGH;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata_out = state_q.rdata;
  assign irq_high_out = state_q.irq_high;
  assign irq_low_out = state_q.irq_low;
  assign irq_vector_out = state_q.vector;

  // Checks. Every property samples on the system clock and sleeps while reset is low.
  // Each event source sets its own flag on the next edge.
  a_conv_flag_set: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    conv_done_in |=> state_q.flags1[IFP_B_CONV])
    else $error("converter flag not set");
  a_t1_flag_set: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    timer_one_overflow_in |=> state_q.flags1[IFP_B_T1O])
    else $error("timer one flag not set");
  a_t2_flag_set: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    timer_two_match_in |=> state_q.flags1[IFP_B_T2M])
    else $error("timer two flag not set");
  a_osc_flag_set: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    osc_fail_in |=> state_q.flags2[IFP_B_OSCF])
    else $error("oscillator flag not set");
  a_nv_flag_set: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    nv_write_done_in |=> state_q.flags2[IFP_B_NVW])
    else $error("write done flag not set");
  // Pin edges are detected outside, so a single pulse must be enough.
  a_pin1_flag_set: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    pin1_event_in |=> state_q.pinctl3[IFP_B_P1FLG])
    else $error("pin one flag not set");
  a_pin2_flag_set: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    pin2_event_in |=> state_q.pinctl3[IFP_B_P2FLG])
    else $error("pin two flag not set");

  // Polling relies on flags that set with every enable and gate clear.
  a_set_no_enable: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    conv_done_in && state_q.en1 == 8'h00 && state_q.core == 8'h00 |=> state_q.flags1[IFP_B_CONV])
    else $error("flag held back by enables");

  // A capture or compare event sets the shared flag; PWM events are ignored.
  a_ccp_flag_set: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    ccp_event_in && (ccp_mode_in == IFP_CCP_CAPTURE || ccp_mode_in == IFP_CCP_COMPARE) |=> state_q.flags1[IFP_B_CAPC])
    else $error("capture flag not set");
  a_ccp_pwm_quiet: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    ccp_event_in && ccp_mode_in == IFP_CCP_PWM && !state_q.flags1[IFP_B_CAPC]
    && !(reg_wr_in && reg_addr_in == IFP_OFF_PFLAG1) |=> !state_q.flags1[IFP_B_CAPC])
    else $error("capture flag set in pwm");

  // Sticky flags hold until software writes their register; one property per software-writable bit.
  // Only bits that software may write are covered here; the buffer levels are checked below.
  for (genvar b = 0; b < 8; b++) begin : g_sticky
    if (IFP_P1_SWMASK[b]) begin : g_one
      a_flag1_sticky: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        state_q.flags1[b] && !(reg_wr_in && reg_addr_in == IFP_OFF_PFLAG1) |=> state_q.flags1[b])
        else $error("flag in register one lost");
    end
    if (IFP_P2_MASK[b]) begin : g_two
      a_flag2_sticky: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        state_q.flags2[b] && !(reg_wr_in && reg_addr_in == IFP_OFF_PFLAG2) |=> state_q.flags2[b])
        else $error("flag in register two lost");
    end
  end

  // Pin flags hold the same way until pin control three is written.
  a_pin_flag_sticky: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    state_q.pinctl3[IFP_B_P1FLG] && !(reg_wr_in && reg_addr_in == IFP_OFF_PINCTL3) |=> state_q.pinctl3[IFP_B_P1FLG])
    else $error("pin flag lost");
  a_pin2_flag_sticky: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    state_q.pinctl3[IFP_B_P2FLG] && !(reg_wr_in && reg_addr_in == IFP_OFF_PINCTL3) |=> state_q.pinctl3[IFP_B_P2FLG])
    else $error("pin two flag lost");

  // Buffer status flags follow the serial unit's levels one cycle late.
  // A buffer access clears the flag at once, even though the level drops only later.
  a_rx_follows: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    1'b1 |=> state_q.flags1[IFP_B_RXF] == $past(serial_rx_full_in && !serial_rx_buffer_read_in))
    else $error("receive flag mismatch");
  a_tx_follows: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    1'b1 |=> state_q.flags1[IFP_B_TXE] == $past(serial_tx_empty_in && !serial_tx_buffer_write_in))
    else $error("transmit flag mismatch");
  a_rx_read_clears: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    serial_rx_buffer_read_in |=> !state_q.flags1[IFP_B_RXF])
    else $error("receive flag not cleared by read");
  a_tx_write_clears: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    serial_tx_buffer_write_in |=> !state_q.flags1[IFP_B_TXE])
    else $error("transmit flag not cleared by write");

  // A hardware set beats a clearing write in the same cycle, on both flag registers.
  a_set_wins: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    osc_fail_in && reg_wr_in && reg_addr_in == IFP_OFF_PFLAG2 |=> state_q.flags2[IFP_B_OSCF])
    else $error("clear beat set");
  a_set_wins_one: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    conv_done_in && reg_wr_in && reg_addr_in == IFP_OFF_PFLAG1 |=> state_q.flags1[IFP_B_CONV])
    else $error("clear beat converter set");

  // Unimplemented positions never hold a one, and unmapped offsets read zero.
  a_unimpl_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    ((state_q.flags1 | state_q.en1 | state_q.pri1) & ~IFP_P1_MASK) == 8'h00 &&
    ((state_q.flags2 | state_q.en2 | state_q.pri2) & ~IFP_P2_MASK) == 8'h00)
    else $error("reserved bit set");
  a_pinctl_unimpl: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (state_q.pinctl3 & ~IFP_PINCTL3_MASK) == 8'h00 && (state_q.core & ~IFP_CORE_MASK) == 8'h00)
    else $error("reserved control bit set");
  a_unmapped_read: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    reg_rd_in && reg_addr_in > IFP_OFF_VECTOR |=> reg_rdata_out == 8'h00)
    else $error("unmapped offset read nonzero");

  // Compatibility mode: one global bit, a peripheral gate, and no low line at all.
  // Priority bits still hold their values here, so software can set them up before switching.
  a_peripheral_irq_global_enable_gate: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    !priority_scheme_enable && !state_q.core[IFP_B_PERIPHERAL_IRQ_GLOBAL_ENABLE] && !pin1_act && !pin2_act |=> !irq_high_out && !irq_low_out)
    else $error("peripheral request without gate");
  a_compat_gie_gate: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    !priority_scheme_enable && !state_q.core[IFP_B_GIE] |=> !irq_high_out && !irq_low_out)
    else $error("request without global enable");
  a_compat_no_low: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    !priority_scheme_enable |=> !irq_low_out)
    else $error("low request without priority scheme");
  a_compat_pri_ignored: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    !priority_scheme_enable && state_q.core[IFP_B_GIE] && state_q.core[IFP_B_PERIPHERAL_IRQ_GLOBAL_ENABLE] && pend1[IFP_B_CONV] |=> irq_high_out)
    else $error("priority bit acted in compatibility mode");
  a_pin_request: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    !priority_scheme_enable && state_q.core[IFP_B_GIE] && pin1_act |=> irq_high_out)
    else $error("pin request not raised");

  // Priority mode: each global bit gates its own line, and high wins over low.
  a_high_gate: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    priority_scheme_enable && !state_q.core[IFP_B_GIE] |=> !irq_high_out)
    else $error("high request without high gate");
  a_low_gate: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    priority_scheme_enable && !state_q.core[IFP_B_PERIPHERAL_IRQ_GLOBAL_ENABLE] |=> !irq_low_out)
    else $error("low request without low gate");
  a_conv_request: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    priority_scheme_enable && state_q.core[IFP_B_PERIPHERAL_IRQ_GLOBAL_ENABLE] && pend1[IFP_B_CONV] && !state_q.pri1[IFP_B_CONV] && !hi_req |=> irq_low_out)
    else $error("low converter request not raised");
  a_high_wins: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    priority_scheme_enable && hi_req |=> irq_high_out && !irq_low_out)
    else $error("high request lost to low");

  // The vector always matches the line that is raised.
  a_low_vector: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    irq_low_out |-> irq_vector_out == IFP_VEC_LOW && !irq_high_out)
    else $error("low vector wrong");
  a_high_vector: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    irq_high_out |-> irq_vector_out == IFP_VEC_HIGH && !irq_low_out)
    else $error("high vector wrong");

endmodule // ifp_irq_ctrl
`default_nettype wire

// file: design/ifp_pkg.sv
// Package for the interrupt flag, enable and priority block.
// Assumes a plain register port with one-cycle strobes and 8-bit data.
package ifp_pkg;
  localparam int unsigned IFP_AW = 4;
  // Register offsets on the plain port.
  localparam logic [3:0] IFP_OFF_PINCTL3 = 4'h0;
  localparam logic [3:0] IFP_OFF_PFLAG1 = 4'h1;
  localparam logic [3:0] IFP_OFF_PFLAG2 = 4'h2;
  localparam logic [3:0] IFP_OFF_PEN1 = 4'h3;
  localparam logic [3:0] IFP_OFF_PEN2 = 4'h4;
  localparam logic [3:0] IFP_OFF_PPRI1 = 4'h5;
  localparam logic [3:0] IFP_OFF_PPRI2 = 4'h6;
  localparam logic [3:0] IFP_OFF_CORECTL = 4'h7;
  localparam logic [3:0] IFP_OFF_VECTOR = 4'h8;
  // Pin control three field positions.
  localparam int unsigned IFP_B_P2PRI = 7;
  localparam int unsigned IFP_B_P1PRI = 6;
  localparam int unsigned IFP_B_P2EN = 4;
  localparam int unsigned IFP_B_P1EN = 3;
  localparam int unsigned IFP_B_P2FLG = 1;
  localparam int unsigned IFP_B_P1FLG = 0;
  localparam logic [7:0] IFP_PINCTL3_MASK = 8'hdb;
  localparam logic [7:0] IFP_PINCTL3_RST = 8'hc0;
  // Peripheral register one layout.
  localparam int unsigned IFP_B_CONV = 6;
  localparam int unsigned IFP_B_RXF = 5;
  localparam int unsigned IFP_B_TXE = 4;
  localparam int unsigned IFP_B_CAPC = 2;
  localparam int unsigned IFP_B_T2M = 1;
  localparam int unsigned IFP_B_T1O = 0;
  localparam logic [7:0] IFP_P1_MASK = 8'h77;
  localparam logic [7:0] IFP_P1_SWMASK = 8'h47;
  // Peripheral register two layout.
  localparam int unsigned IFP_B_OSCF = 7;
  localparam int unsigned IFP_B_NVW = 4;
  localparam int unsigned IFP_B_LOWV = 2;
  localparam int unsigned IFP_B_T3O = 1;
  localparam logic [7:0] IFP_P2_MASK = 8'h96;
  // Core control fields.
  localparam int unsigned IFP_B_GIE = 7;
  localparam int unsigned IFP_B_PERIPHERAL_IRQ_GLOBAL_ENABLE = 6;
  localparam int unsigned IFP_B_PRIORITY_SCHEME_ENABLE = 0;
  localparam logic [7:0] IFP_CORE_MASK = 8'hc1;
  // Vector addresses.
  localparam logic [23:0] IFP_VEC_HIGH = 24'h000008;
  localparam logic [23:0] IFP_VEC_LOW = 24'h000018;
  // Capture/compare unit modes.
  typedef enum logic [1:0] {IFP_CCP_CAPTURE, IFP_CCP_COMPARE, IFP_CCP_PWM, IFP_CCP_OFF} ifp_ccp_mode_type;
endpackage

// file: test/ifp_irq_ctrl_tb.sv
// Self-checking bench for the interrupt flag, enable and priority block.
// Assumes the source model in ifp_src_model.sv and the register offsets of ifp_pkg.
`timescale 1ns/10ps
`default_nettype none
module ifp_irq_ctrl_tb;
  import ifp_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rx_rd = 1'b0;
  logic tx_wr = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [11:0] fire = 12'h000;
  logic [7:0] rdata;
  logic hi;
  logic lo;
  logic [23:0] vec;
  logic [9:0] ev;
  logic rx_full;
  logic tx_empty;
  int n_fail = 0;
  int n_compared = 0;
  // Event order: pin1, pin2, converter, capcomp, timer two, timer one, osc, nv, low voltage, timer three.
  logic [3:0] ev_off [10] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h2};
  int ev_bit [10] = '{0, 1, 6, 2, 1, 0, 7, 4, 2, 1};
  logic [7:0] rst_v [10] = '{8'hc0, 8'h10, 8'h00, 8'h00, 8'h00, 8'h77, 8'h96, 8'h00, 8'h08, 8'h00};
  logic [7:0] ff_v [8] = '{8'hdb, 8'h57, 8'h96, 8'h77, 8'h96, 8'h77, 8'h96, 8'hc1};
  localparam logic [25:0] LVL = 26'h3000000;
  // Free-running system clock, 100 ns period.
  always #50 clk = ~clk;
  ifp_irq_ctrl DUT (.sys_clk_in(clk), .rst_b_in(rst_b), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .pin1_event_in(ev[0]), .pin2_event_in(ev[1]),
    .conv_done_in(ev[2]), .serial_rx_full_in(rx_full), .serial_tx_empty_in(tx_empty),
    .serial_rx_buffer_read_in(rx_rd), .serial_tx_buffer_write_in(tx_wr), .ccp_mode_in(mode),
    .ccp_event_in(ev[3]), .timer_two_match_in(ev[4]), .timer_one_overflow_in(ev[5]), .osc_fail_in(ev[6]),
    .nv_write_done_in(ev[7]), .low_voltage_in(ev[8]), .timer_three_overflow_in(ev[9]),
    .irq_high_out(hi), .irq_low_out(lo), .irq_vector_out(vec));
  ifp_src_model SRC (.sys_clk_in(clk), .rst_b_in(rst_b), .fire_in(fire), .rx_read_in(rx_rd),
    .tx_write_in(tx_wr), .ev_out(ev), .rx_full_out(rx_full), .tx_empty_out(tx_empty));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  // Compares the request lines and vector under a mask, since the vector means nothing when idle.
  task automatic chk_irq(input logic [25:0] exp, input logic [25:0] m);
    #1;
    n_compared++;
    if ((({hi, lo, vec}) & m) !== (exp & m)) begin
      n_fail++;
      $display("CHECK FAILED at %0t: requests %b %b vector %h", $time, hi, lo, vec);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    fire <= 12'h001 << i;
    @(posedge clk);
    fire <= 12'h000;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 10; i++) rd_chk(i[3:0], rst_v[i]);
    for (int i = 0; i < 8; i++) wr_reg(i[3:0], 8'hff);
    for (int i = 0; i < 8; i++) rd_chk(i[3:0], ff_v[i]);
    wr_reg(4'h9, 8'hff);
    rd_chk(4'h9, 8'h00);
    for (int i = 0; i < 8; i++) wr_reg(i[3:0], 8'h00);
    for (int i = 0; i < 8; i++) rd_chk(i[3:0], (i == 1) ? 8'h10 : 8'h00);
    wr_reg(4'h5, 8'h77);
    wr_reg(4'h6, 8'h96);
    $display("test registers done");
  endtask
  task automatic t_flags;
    for (int i = 0; i < 10; i++) begin
      pulse(i);
      rd_chk(ev_off[i], (8'h01 << ev_bit[i]) | ((ev_off[i] == 4'h1) ? 8'h10 : 8'h00));
      wr_reg(ev_off[i], 8'h00);
      rd_chk(ev_off[i], (ev_off[i] == 4'h1) ? 8'h10 : 8'h00);
    end
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      mode <= m[1:0];
      pulse(3);
      rd_chk(4'h1, (m < 2) ? 8'h14 : 8'h10);
      wr_reg(4'h1, 8'h00);
    end
    $display("test flags done");
  endtask
  task automatic t_serial;
    pulse(10);
    rd_chk(4'h1, 8'h30);
    @(posedge clk);
    rx_rd <= 1'b1;
    @(posedge clk);
    rx_rd <= 1'b0;
    rd_chk(4'h1, 8'h10);
    @(posedge clk);
    tx_wr <= 1'b1;
    @(posedge clk);
    tx_wr <= 1'b0;
    rd_chk(4'h1, 8'h00);
    pulse(11);
    rd_chk(4'h1, 8'h10);
    // A clearing write taken on the same edge as the converter event must lose.
    @(posedge clk);
    fire <= 12'h004;
    @(posedge clk);
    fire <= 12'h000;
    addr <= 4'h1;
    wdata <= 8'h00;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd_chk(4'h1, 8'h50);
    wr_reg(4'h1, 8'h00);
    $display("test serial done");
  endtask
  task automatic t_irq;
    wr_reg(4'h1, 8'h00);
    wr_reg(4'h3, 8'h40);
    pulse(2);
    wr_reg(4'h7, 8'h80);
    repeat (3) @(posedge clk);
    chk_irq(26'h0, LVL);
    wr_reg(4'h5, 8'h37);
    wr_reg(4'h7, 8'hc0);
    repeat (3) @(posedge clk);
    chk_irq({2'b10, IFP_VEC_HIGH}, '1);
    wr_reg(4'h7, 8'hc1);
    repeat (3) @(posedge clk);
    chk_irq({2'b01, IFP_VEC_LOW}, '1);
    rd_chk(4'h8, IFP_VEC_LOW[7:0]);
    wr_reg(4'h7, 8'h81);
    repeat (3) @(posedge clk);
    chk_irq(26'h0, LVL);
    wr_reg(4'h7, 8'h80);
    wr_reg(4'h3, 8'h00);
    wr_reg(4'h0, 8'h08);
    pulse(0);
    chk_irq({2'b10, IFP_VEC_HIGH}, '1);
    wr_reg(4'h0, 8'h08);
    repeat (3) @(posedge clk);
    chk_irq(26'h0, LVL);
    $display("test requests done");
  endtask
  task automatic results;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Main sequence; reset is held for ten cycles first.
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_flags();
    t_serial();
    t_irq();
    results();
  end
  // Cuts a hang short well beyond the length of the whole sequence.
  initial begin
    #3000000;
    n_fail++;
    $display("CHECK FAILED at %0t: run limit reached", $time);
    results();
  end
endmodule // ifp_irq_ctrl_tb
`default_nettype wire

// file: test/ifp_src_model.sv
// Partner model: peripheral event sources and the serial buffer levels.
// Assumes the bench raises one-cycle requests on fire_in just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module ifp_src_model (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Bench requests: 9..0 events, 10 receive arrival, 11 transmit done.
  input wire logic [11:0] fire_in,
  input wire logic rx_read_in,
  input wire logic tx_write_in,
  // Toward the block.
  output logic [9:0] ev_out,
  output logic rx_full_out,
  output logic tx_empty_out
);
  // Events leave as registered one-cycle strobes; buffer levels hold until the buffer is accessed.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ev_out <= 10'h000;
      rx_full_out <= 1'b0;
      tx_empty_out <= 1'b1; // An idle transmitter has an empty buffer.
    end else begin
      ev_out <= fire_in[9:0];
      if (fire_in[10]) rx_full_out <= 1'b1;
      else if (rx_read_in) rx_full_out <= 1'b0;
      if (fire_in[11]) tx_empty_out <= 1'b1;
      else if (tx_write_in) tx_empty_out <= 1'b0;
    end
  end
endmodule // ifp_src_model
`default_nettype wire
